// ===== hw/rxgc_pkg.sv
// Purpose: shared constants and carriers for the receive gain, squelch and strength block
// Assumes: 40 MHz pclk, APB with 32-bit data
// Notes:   byte offsets are chosen locally, one aligned word per register
package rxgc_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [11:0] RXGC_OFS_CFG2      = 12'h000;
	localparam logic [11:0] RXGC_OFS_CFG4      = 12'h004;
	localparam logic [11:0] RXGC_OFS_SQT       = 12'h008;
	localparam logic [11:0] RXGC_OFS_CORR1     = 12'h00c;
	localparam logic [11:0] RXGC_OFS_CORR2     = 12'h010;
	localparam logic [11:0] RXGC_OFS_GAIN_STAT = 12'h014;
	localparam logic [11:0] RXGC_OFS_RSSI      = 12'h018;
	localparam logic [11:0] RXGC_OFS_CMD       = 12'h01c;
	localparam logic [11:0] RXGC_OFS_LIVE      = 12'h020;

	// cfg2 field positions
	localparam int RXGC_B_SQM_DYN   = 0;
	localparam int RXGC_B_SQ_RATIO  = 1;
	localparam int RXGC_B_AGC_EN    = 2;
	localparam int RXGC_B_AGC_MODE  = 3;
	localparam int RXGC_B_AGC_ALG   = 4;
	localparam int RXGC_B_AGC_RATIO = 5;
	localparam int RXGC_B_MAN_WIN   = 6;
	// command bits
	localparam int RXGC_B_CMD_GAIN_RST = 0;
	localparam int RXGC_B_CMD_STR_CLR  = 1;

	// reset values
	localparam logic [7:0] RXGC_RST_CFG2  = 8'h00;
	localparam logic [7:0] RXGC_RST_CFG4  = 8'h00;
	localparam logic [7:0] RXGC_RST_SQT   = 8'h00;
	localparam logic [7:0] RXGC_RST_CORR  = 8'h00;

	// gain steps: 0 min window, 1..4 wider window, 5..10 less gain
	localparam logic [3:0] RXGC_STEP_MAX     = 4'ha;
	localparam logic [3:0] RXGC_WIN_STEPS    = 4'h4;
	localparam logic [3:0] RXGC_RSSI_MAX     = 4'hd;
	localparam logic [3:0] RXGC_SQ_MAX_TRANS = 4'h2;
	localparam int         RXGC_AGC_PULSES   = 8;

	// timing
	localparam int RXGC_CLK_KHZ        = 40000;
	localparam int RXGC_SQ_DELAY_NS    = 18880;
	localparam int RXGC_SQ_PERIOD_US   = 50;
	localparam int RXGC_SQ_DELAY_CYC   = (RXGC_SQ_DELAY_NS * RXGC_CLK_KHZ + 999999) / 1000000;
	localparam int RXGC_SQ_PERIOD_CYC  = RXGC_SQ_PERIOD_US * RXGC_CLK_KHZ / 1000;

	// analog control carrier
	typedef struct packed {
		logic [2:0] win_sel;     // digitizer window, 0..4
		logic [2:0] gain_cut;    // stage two and three cut, 0..6
		logic       sq_ratio6;   // squelch watches 6x comparator
		logic       agc_ratio6;  // agc comparator at 6x else 3x
		logic [7:0] corr1;
		logic [7:0] corr2;
	} rxgc_ana_t;
endpackage

// ===== hw/rxgc_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: input asynchronous to pclk
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module rxgc_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// chain; first stage only feeds the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// accept a bit only when the two later stages agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					q[i] <= 1'b0;
				end else if (s2_r[i] == s3_r[i]) begin
					q[i] <= s3_r[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== hw/rxgc_edge_cnt.sv
// Purpose: counts transitions, both directions, of a synchronised comparator output
// Assumes: input already in pclk domain
// Notes:   saturates, cleared by clr which wins over a same-cycle edge count
`timescale 1ns/1ps
`default_nettype none
module rxgc_edge_cnt #(
	parameter int CW = 4
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          sig,
	input  wire logic          clr,
	output logic      [CW-1:0] cnt,
	output logic               edge_seen
);
	logic sig_d_r;
	logic tog;

	// any transition counts, both directions
	assign tog = sig ^ sig_d_r;
	assign edge_seen = tog;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sig_d_r <= 1'b0;
		end else begin
			sig_d_r <= sig;
		end
	end

	// clear starts a fresh window, so it must drop the old count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (clr) begin
			cnt <= '0;
		end else if (tog && cnt != {CW{1'b1}}) begin
			cnt <= cnt + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== hw/rxgc_top.sv
// Purpose: gain reduction, squelch, agc, strength hold and correlator setup
// Assumes: comparator, rssi and subcarrier inputs are asynchronous pins
// Notes:   tx_end and mrt_count come from logic on pclk
`timescale 1ns/1ps
`default_nettype none
// How it works
// - digitizer window comparator has five widths in 3 dB steps.
// - manual window setting overrides the loops' window when selected; gain cut still follows the step.
// - eleven gain steps: window steps first, then six gain cuts.
// - start step comes from programmed initial setting.
// - live gain step is readable.
// - dynamic squelch starts 18.88 us after tx end, stops at squelch timer.
// - squelch ratio 1 or 6 chosen by a config bit.
// - ratio 1 cuts one step per 50 us period with over two transitions.
// - ratio 6 does the same on the six-times comparator.
// - gain reset command clears squelch gain.
// - gain reset reinitialises loops and loads the programmed start step.
// - agc runs only while receive window high, reset otherwise.
// - falling receive window latches gain step into status.
// - agc comparator at 3x or 6x, cuts until no transitions.
// - agc enable and mode: whole window or first eight pulses.
// - preset starts at max window, or at the start step if higher; reset starts at the programmed start step.
// - strength restarts at zero on window rise, peak hold, frozen low.
// - strength restarts whenever agc lowers gain.
// - strength is 4-bit, saturates at 13.
// - strength clear command clears value and restarts.
// - two correlator configuration registers feed the correlators.
module rxgc_top (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                rx_on,
	input  wire logic                tx_end,
	input  wire logic [7:0]          mrt_count,
	input  wire logic                dig_in,
	input  wire logic                sq6_in,
	input  wire logic                agc_cmp_in,
	input  wire logic [3:0]          rssi_am_in,
	input  wire logic [3:0]          rssi_pm_in,
	output rxgc_pkg::rxgc_ana_t      ana,
	output logic                     dig_out
);
	// ************************************************************
	// registers and bus
	// ************************************************************
	logic [7:0] cfg2_r;
	logic [7:0] cfg4_r;
	logic [7:0] sqt_r;
	logic [7:0] corr1_r;
	logic [7:0] corr2_r;
	logic [3:0] gain_stat_r;
	logic [3:0] rssi_am_r;
	logic [3:0] rssi_pm_r;
	logic [3:0] step_r;
	logic [3:0] step_nxt;
	logic       gain_rst_r;
	logic       str_clr_r;
	logic       rx_on_d_r;

	logic       wr_en;
	logic       rd_en;
	logic       hit;
	logic [3:0] start_step;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;

	function automatic logic map_hit(input logic [11:0] a);
		map_hit = (a == rxgc_pkg::RXGC_OFS_CFG2) || (a == rxgc_pkg::RXGC_OFS_CFG4) ||
			(a == rxgc_pkg::RXGC_OFS_SQT) || (a == rxgc_pkg::RXGC_OFS_CORR1) ||
			(a == rxgc_pkg::RXGC_OFS_CORR2) || (a == rxgc_pkg::RXGC_OFS_GAIN_STAT) ||
			(a == rxgc_pkg::RXGC_OFS_RSSI) || (a == rxgc_pkg::RXGC_OFS_CMD) ||
			(a == rxgc_pkg::RXGC_OFS_LIVE);
	endfunction

	assign hit = map_hit(paddr);

	// zero-wait slave: ready in every access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !map_hit(paddr);
		end
	end

	// configuration writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg2_r  <= rxgc_pkg::RXGC_RST_CFG2;
			cfg4_r  <= rxgc_pkg::RXGC_RST_CFG4;
			sqt_r   <= rxgc_pkg::RXGC_RST_SQT;
			corr1_r <= rxgc_pkg::RXGC_RST_CORR;
			corr2_r <= rxgc_pkg::RXGC_RST_CORR;
		end else if (wr_en && pready) begin
			case (paddr)
				rxgc_pkg::RXGC_OFS_CFG2:  cfg2_r  <= pwdata[7:0];
				rxgc_pkg::RXGC_OFS_CFG4:  cfg4_r  <= pwdata[7:0];
				rxgc_pkg::RXGC_OFS_SQT:   sqt_r   <= pwdata[7:0];
				rxgc_pkg::RXGC_OFS_CORR1: corr1_r <= pwdata[7:0];
				rxgc_pkg::RXGC_OFS_CORR2: corr2_r <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// direct commands are one-cycle pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_rst_r <= 1'b0;
			str_clr_r  <= 1'b0;
		end else begin
			gain_rst_r <= wr_en && pready && paddr == rxgc_pkg::RXGC_OFS_CMD &&
				pwdata[rxgc_pkg::RXGC_B_CMD_GAIN_RST];
			str_clr_r  <= wr_en && pready && paddr == rxgc_pkg::RXGC_OFS_CMD &&
				pwdata[rxgc_pkg::RXGC_B_CMD_STR_CLR];
		end
	end

	// read mux, registered so data sits with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				rxgc_pkg::RXGC_OFS_CFG2:      prdata <= {24'h000000, cfg2_r};
				rxgc_pkg::RXGC_OFS_CFG4:      prdata <= {24'h000000, cfg4_r};
				rxgc_pkg::RXGC_OFS_SQT:       prdata <= {24'h000000, sqt_r};
				rxgc_pkg::RXGC_OFS_CORR1:     prdata <= {24'h000000, corr1_r};
				rxgc_pkg::RXGC_OFS_CORR2:     prdata <= {24'h000000, corr2_r};
				rxgc_pkg::RXGC_OFS_GAIN_STAT: prdata <= {28'h0000000, gain_stat_r};
				rxgc_pkg::RXGC_OFS_RSSI:      prdata <= {24'h000000, rssi_pm_r, rssi_am_r};
				rxgc_pkg::RXGC_OFS_LIVE:      prdata <= {28'h0000000, step_r};
				default:                      prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic       dig_s;
	logic       sq6_s;
	logic       agc_s;
	logic       rx_on_s;
	logic [3:0] am_s;
	logic [3:0] pm_s;

	rxgc_sync #(.W(12)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({dig_in, sq6_in, agc_cmp_in, rx_on, rssi_am_in, rssi_pm_in}),
		.q       ({dig_s, sq6_s, agc_s, rx_on_s, am_s, pm_s})
	);

	logic rx_rise;
	logic rx_fall;
	assign rx_rise = rx_on_s && !rx_on_d_r;
	assign rx_fall = !rx_on_s && rx_on_d_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_on_d_r <= 1'b0;
		end else begin
			rx_on_d_r <= rx_on_s;
		end
	end

	// ************************************************************
	// squelch
	// ************************************************************
	localparam int DW = $clog2(rxgc_pkg::RXGC_SQ_PERIOD_CYC + 1);
	logic [DW-1:0] sq_tmr_r;
	logic          sq_wait_r;
	logic          sq_act_r;
	logic          sq_period_end;
	logic          sq_src;
	logic [3:0]    sq_cnt;
	logic          sq_cut;

	assign sq_src = cfg2_r[rxgc_pkg::RXGC_B_SQ_RATIO] ? sq6_s : dig_s;
	assign sq_period_end = sq_act_r &&
		sq_tmr_r == DW'(rxgc_pkg::RXGC_SQ_PERIOD_CYC - 1);

	// delay after tx end, then windows until mrt hits the squelch time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sq_wait_r <= 1'b0;
			sq_act_r  <= 1'b0;
			sq_tmr_r  <= '0;
		end else if (gain_rst_r) begin
			sq_wait_r <= 1'b0;
			sq_act_r  <= 1'b0;
			sq_tmr_r  <= '0;
		end else if (tx_end && cfg2_r[rxgc_pkg::RXGC_B_SQM_DYN]) begin
			sq_wait_r <= 1'b1;
			sq_act_r  <= 1'b0;
			sq_tmr_r  <= '0;
		end else if (sq_wait_r) begin
			if (sq_tmr_r == DW'(rxgc_pkg::RXGC_SQ_DELAY_CYC - 1)) begin
				sq_wait_r <= 1'b0;
				sq_act_r  <= 1'b1;
				sq_tmr_r  <= '0;
			end else begin
				sq_tmr_r <= sq_tmr_r + 1'b1;
			end
		end else if (sq_act_r) begin
			if (mrt_count == sqt_r) begin
				sq_act_r <= 1'b0;
			end
			sq_tmr_r <= sq_period_end ? '0 : sq_tmr_r + 1'b1;
		end
	end

	rxgc_edge_cnt #(.CW(4)) u_sq_cnt (
		.pclk      (pclk),
		.presetn   (presetn),
		.sig       (sq_src),
		.clr       (sq_period_end || !sq_act_r),
		.cnt       (sq_cnt),
		.edge_seen ()
	);

	assign sq_cut = sq_period_end && sq_cnt > rxgc_pkg::RXGC_SQ_MAX_TRANS;

	// ************************************************************
	// agc
	// ************************************************************
	logic       agc_edge;
	logic       dig_edge;
	// agc needs only the edge flag, so that counter is held clear
	logic [3:0] pulse_cnt_r;
	logic       agc_run;
	logic       agc_cut;

	rxgc_edge_cnt #(.CW(4)) u_agc_cnt (
		.pclk      (pclk),
		.presetn   (presetn),
		.sig       (agc_s),
		.clr       (1'b1),
		.cnt       (),
		.edge_seen (agc_edge)
	);

	rxgc_edge_cnt #(.CW(4)) u_dig_cnt (
		.pclk      (pclk),
		.presetn   (presetn),
		.sig       (dig_s),
		.clr       (!rx_on_s),
		.cnt       (),
		.edge_seen (dig_edge)
	);

	// subcarrier pulse count, held in reset outside the window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_cnt_r <= 4'h0;
		end else if (!rx_on_s) begin
			pulse_cnt_r <= 4'h0;
		end else if (dig_edge && dig_s && pulse_cnt_r != 4'(rxgc_pkg::RXGC_AGC_PULSES)) begin
			pulse_cnt_r <= pulse_cnt_r + 1'b1;
		end
	end

	// mode 1 limits adaptation to the first eight pulses
	assign agc_run = cfg2_r[rxgc_pkg::RXGC_B_AGC_EN] && rx_on_s &&
		(!cfg2_r[rxgc_pkg::RXGC_B_AGC_MODE] ||
		pulse_cnt_r != 4'(rxgc_pkg::RXGC_AGC_PULSES));
	// any transition on the 3x or 6x comparator means still too loud
	assign agc_cut = agc_run && agc_edge;

	// ************************************************************
	// shared gain step
	// ************************************************************
	assign start_step = (cfg4_r[3:0] > rxgc_pkg::RXGC_STEP_MAX) ?
		rxgc_pkg::RXGC_STEP_MAX : cfg4_r[3:0];

	always_comb begin
		step_nxt = step_r;
		if (gain_rst_r) begin
			step_nxt = start_step;
		end else if (rx_rise && cfg2_r[rxgc_pkg::RXGC_B_AGC_EN]) begin
			// preset jumps to widest window; never below start
			if (cfg2_r[rxgc_pkg::RXGC_B_AGC_ALG] && start_step < rxgc_pkg::RXGC_WIN_STEPS) begin
				step_nxt = rxgc_pkg::RXGC_WIN_STEPS;
			end else begin
				step_nxt = start_step;
			end
		end else if ((sq_cut || agc_cut) && step_r < rxgc_pkg::RXGC_STEP_MAX) begin
			step_nxt = step_r + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_r <= 4'h0;
		end else begin
			step_r <= step_nxt;
		end
	end

	// status snapshot on each window close
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_stat_r <= 4'h0;
		end else if (rx_fall) begin
			gain_stat_r <= step_r;
		end
	end

	// ************************************************************
	// strength peak hold
	// ************************************************************
	logic rssi_clr;
	assign rssi_clr = rx_rise || gain_rst_r || str_clr_r ||
		(agc_cut && step_r < rxgc_pkg::RXGC_STEP_MAX);

	function automatic logic [3:0] peak(input logic [3:0] held, input logic [3:0] v);
		logic [3:0] s;
		s = (v > rxgc_pkg::RXGC_RSSI_MAX) ? rxgc_pkg::RXGC_RSSI_MAX : v;
		peak = (s > held) ? s : held;
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rssi_am_r <= 4'h0;
			rssi_pm_r <= 4'h0;
		end else if (rssi_clr) begin
			rssi_am_r <= 4'h0;
			rssi_pm_r <= 4'h0;
		end else if (rx_on_s) begin
			rssi_am_r <= peak(rssi_am_r, am_s);
			rssi_pm_r <= peak(rssi_pm_r, pm_s);
		end
	end

	// ************************************************************
	// analog controls
	// ************************************************************
	logic [3:0] eff_step;
	assign eff_step = cfg2_r[rxgc_pkg::RXGC_B_MAN_WIN] ?
		{1'b0, (cfg4_r[6:4] > 3'h4) ? 3'h4 : cfg4_r[6:4]} : step_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ana     <= '0;
			dig_out <= 1'b0;
		end else begin
			ana.win_sel    <= (eff_step > rxgc_pkg::RXGC_WIN_STEPS) ? 3'h4 : eff_step[2:0];
			ana.gain_cut   <= (step_r > rxgc_pkg::RXGC_WIN_STEPS) ?
				3'(step_r - rxgc_pkg::RXGC_WIN_STEPS) : 3'h0;
			ana.sq_ratio6  <= cfg2_r[rxgc_pkg::RXGC_B_SQ_RATIO];
			ana.agc_ratio6 <= cfg2_r[rxgc_pkg::RXGC_B_AGC_RATIO];
			ana.corr1      <= corr1_r;
			ana.corr2      <= corr2_r;
			dig_out        <= dig_s;
		end
	end
endmodule
`default_nettype wire

// ===== tb/rxgc_checker.sv
// Purpose: port checks on the gain, squelch and strength block
// Assumes: zero-wait apb slave, one clock domain
// Notes:   bound onto rxgc_top below
`timescale 1ns/1ps
`default_nettype none
module rxgc_checker (
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic                dig_in,
	input wire rxgc_pkg::rxgc_ana_t ana,
	input wire logic                dig_out
);
	// ****************
	// checks
	// ****************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// completed access and address decode
	wire logic acc = psel && penable && pready;
	wire logic rd  = acc && !pwrite;
	wire logic hit = (paddr[1:0] == 2'h0) && (paddr <= rxgc_pkg::RXGC_OFS_LIVE);
	AST_PREADY_SETUP: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready held too long");
	AST_SLVERR_MAP: assert property (acc |-> pslverr == !hit)
		else $error("pslverr does not match decode");
	AST_READ_UPPER: assert property (rd |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	AST_RSSI_SAT: assert property (rd && paddr == rxgc_pkg::RXGC_OFS_RSSI |->
		prdata[3:0] <= 4'hd && prdata[7:4] <= 4'hd) else $error("strength above 13");
	AST_STEP_MAX: assert property (rd && paddr == rxgc_pkg::RXGC_OFS_LIVE |->
		prdata[3:0] <= 4'ha) else $error("gain step above ten");
	AST_ANA_RANGE: assert property (ana.win_sel <= 3'h4 && ana.gain_cut <= 3'h6)
		else $error("window or gain cut out of range");
	AST_CORR1: assert property (acc && pwrite && paddr == rxgc_pkg::RXGC_OFS_CORR1 |->
		##2 ana.corr1 == $past(pwdata[7:0], 2)) else $error("corr1 not applied");
	AST_CORR2: assert property (acc && pwrite && paddr == rxgc_pkg::RXGC_OFS_CORR2 |->
		##2 ana.corr2 == $past(pwdata[7:0], 2)) else $error("corr2 not applied");
	AST_RATIO: assert property (acc && pwrite && paddr == rxgc_pkg::RXGC_OFS_CFG2 |-> ##2
		ana.sq_ratio6 == $past(pwdata[rxgc_pkg::RXGC_B_SQ_RATIO], 2)
		&& ana.agc_ratio6 == $past(pwdata[rxgc_pkg::RXGC_B_AGC_RATIO], 2))
		else $error("ratio selects not applied");
	AST_DIG_FOLLOW: assert property ($stable(dig_in) [*8] |-> dig_out == dig_in)
		else $error("digitizer output lags input");
endmodule
bind rxgc_top rxgc_checker u_rxgc_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .dig_in(dig_in), .ana(ana), .dig_out(dig_out));
`default_nettype wire

// ===== tb/rxgc_ana_model.sv
// Purpose: analog chain stand-in driving the comparator pins
// Assumes: step equals win_sel plus gain_cut while manual window is off
// Notes:   toggles every 20 cycles so sync latency cannot overshoot
`timescale 1ns/1ps
`default_nettype none
module rxgc_ana_model (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire rxgc_pkg::rxgc_ana_t ana,
	input  wire logic [3:0]          agc_tgt,
	input  wire logic [3:0]          sq_tgt,
	input  wire logic [3:0]          sq6_tgt,
	output logic                     dig_in,
	output logic                     sq6_in,
	output logic                     agc_cmp_in
);
	logic [3:0] step;
	logic [4:0] ph_r;
	// gain state as seen by the chain
	assign step = {1'b0, ana.win_sel} + {1'b0, ana.gain_cut};
	// toggle phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ph_r <= 5'h00;
		else ph_r <= (ph_r == 5'h13) ? 5'h00 : ph_r + 5'h01;
	end
	// noise on each comparator until the gain is cut far enough
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dig_in <= 1'b0;
			sq6_in <= 1'b0;
			agc_cmp_in <= 1'b0;
		end else if (ph_r == 5'h13) begin
			dig_in <= dig_in ^ (step < sq_tgt);
			sq6_in <= sq6_in ^ (step < sq6_tgt);
			agc_cmp_in <= agc_cmp_in ^ (step < agc_tgt);
		end
	end
endmodule
`default_nettype wire

// ===== tb/rx_gain_squelch_rssi_control_tb_top.sv
// Purpose: self-checking bench for the gain, squelch and strength block
// Assumes: zero-wait apb slave, comparator pins from rxgc_ana_model
// Notes:   expected steps come from the bench loop model, not the design
`timescale 1ns/1ps
`default_nettype none
module rx_gain_squelch_rssi_control_tb_top;
	logic                pclk, presetn, psel, penable, pwrite, rx_on, tx_end;
	logic                pready, pslverr, dig_out, dig_in, sq6_in, agc_cmp_in, rerr;
	logic [11:0]         paddr;
	logic [11:0]         ofs [8];
	logic [31:0]         pwdata, prdata, rdat;
	logic [7:0]          mrt_count, sqt;
	logic [3:0]          am, pm, agc_tgt, sq_tgt, sq6_tgt;
	logic [19:0]         wq [$];
	rxgc_pkg::rxgc_ana_t ana;
	int                  error_cnt, checks, s;
	rxgc_top u_rxgc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_on(rx_on), .tx_end(tx_end), .mrt_count(mrt_count),
		.dig_in(dig_in), .sq6_in(sq6_in), .agc_cmp_in(agc_cmp_in), .rssi_am_in(am),
		.rssi_pm_in(pm), .ana(ana), .dig_out(dig_out));
	rxgc_ana_model u_rxgc_ana_model (.pclk(pclk), .presetn(presetn), .ana(ana),
		.agc_tgt(agc_tgt), .sq_tgt(sq_tgt), .sq6_tgt(sq6_tgt), .dig_in(dig_in),
		.sq6_in(sq6_in), .agc_cmp_in(agc_cmp_in));
	// ****************
	// helpers
	// ****************
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// one transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			chk("pready", 32'h1, {31'h0, pready});
			close_out();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rdat);
	endtask
	// poll the live step, bounded
	task automatic wait_live(input int exp);
		for (int i = 0; i < 60; i++) begin
			apb(1'b0, rxgc_pkg::RXGC_OFS_LIVE, 32'h0);
			if (rdat === exp) break;
			repeat (200) @(posedge pclk);
		end
		chk("live step", exp, rdat);
		if (rdat !== exp) close_out();
	endtask
	// config, start step, then gain reset command
	task automatic setup(input logic [7:0] c2, input logic [7:0] c4);
		apb(1'b1, rxgc_pkg::RXGC_OFS_CFG2, {24'h0, c2});
		apb(1'b1, rxgc_pkg::RXGC_OFS_CFG4, {24'h0, c4});
		apb(1'b1, rxgc_pkg::RXGC_OFS_CMD, 32'h1);
		wait_live(c4[3:0]);
	endtask
	task automatic chk_ana(input int st, input int w);
		chk("win_sel", w, {29'h0, ana.win_sel});
		chk("gain_cut", (st > 4) ? st - 4 : 0, {29'h0, ana.gain_cut});
	endtask
	task automatic pulse_tx();
		@(posedge pclk);
		tx_end <= 1'b1;
		@(posedge pclk);
		tx_end <= 1'b0;
	endtask
	// agc end step: preset floor at four, loops only cut, stop at ten
	function automatic int agc_end(int st, int pre, int tgt);
		int b;
		b = (pre != 0 && st < 4) ? 4 : st;
		if (tgt > b) b = tgt;
		return (b > 10) ? 10 : b;
	endfunction
	// ****************
	// clock and sequence
	// ****************
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		{psel, penable, pwrite, rx_on, tx_end} = 5'h00;
		{paddr, pwdata, mrt_count} = 52'h0;
		{am, pm, agc_tgt, sq_tgt, sq6_tgt} = 20'h0;
		{error_cnt, checks} = 0;
		ofs = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h020};
		presetn = 1'b0;
		void'($urandom(32'h1138902e));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ofs[i]) rd(ofs[i], 32'h0, "reset value");
		apb(1'b0, 12'h024, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, rerr});
		for (s = 2; s < 5; s++) begin
			wq.push_back({ofs[s], 8'($urandom_range(255, 1))});
			apb(1'b1, wq[$][19:8], {24'h0, wq[$][7:0]});
		end
		sqt = wq[0][7:0];
		while (wq.size() > 0) begin
			rd(wq[0][19:8], {24'h0, wq[0][7:0]}, "readback");
			void'(wq.pop_front());
		end
		for (s = 0; s <= 10; s++) begin
			setup(8'h00, s[7:0]);
			chk_ana(s, (s > 4) ? 4 : s);
		end
		setup(8'h40, 8'h37);
		chk_ana(7, 3);
		am <= 4'hf;
		pm <= 4'h5;
		agc_tgt <= 4'h7;
		setup(8'h04, 8'h02);
		rx_on <= 1'b1;
		wait_live(agc_end(2, 0, 7));
		chk_ana(7, 4);
		repeat (20) @(posedge pclk);
		rd(rxgc_pkg::RXGC_OFS_RSSI, 32'h5d, "strength");
		am <= 4'h3;
		pm <= 4'h2;
		agc_tgt <= 4'h8;
		wait_live(8);
		repeat (20) @(posedge pclk);
		rd(rxgc_pkg::RXGC_OFS_RSSI, 32'h23, "strength");
		am <= 4'h1;
		pm <= 4'h1;
		repeat (20) @(posedge pclk);
		rd(rxgc_pkg::RXGC_OFS_RSSI, 32'h23, "strength");
		apb(1'b1, rxgc_pkg::RXGC_OFS_CMD, 32'h2);
		repeat (10) @(posedge pclk);
		rd(rxgc_pkg::RXGC_OFS_RSSI, 32'h11, "strength");
		rx_on <= 1'b0;
		am <= 4'h9;
		repeat (20) @(posedge pclk);
		rd(rxgc_pkg::RXGC_OFS_GAIN_STAT, 32'h8, "gain status");
		rd(rxgc_pkg::RXGC_OFS_RSSI, 32'h11, "strength");
		agc_tgt <= 4'h0;
		setup(8'h34, 8'h00);
		rx_on <= 1'b1;
		wait_live(agc_end(0, 1, 0));
		agc_tgt <= 4'h2;
		repeat (200) @(posedge pclk);
		rd(rxgc_pkg::RXGC_OFS_LIVE, 32'h4, "live preset");
		agc_tgt <= 4'hf;
		wait_live(agc_end(0, 1, 15));
		// mode 1: eight quiet pulses first, later agc noise must not cut
		rx_on <= 1'b0;
		agc_tgt <= 4'h0;
		sq_tgt <= 4'hf;
		setup(8'h0c, 8'h02);
		rx_on <= 1'b1;
		repeat (500) @(posedge pclk);
		agc_tgt <= 4'hf;
		repeat (200) @(posedge pclk);
		rd(rxgc_pkg::RXGC_OFS_LIVE, 32'h2, "live mode one");
		rx_on <= 1'b0;
		agc_tgt <= 4'h0;
		setup(8'h01, 8'h00);
		sq_tgt <= 4'h3;
		pulse_tx();
		repeat (700) @(posedge pclk);
		rd(rxgc_pkg::RXGC_OFS_LIVE, 32'h0, "live early");
		wait_live(3);
		repeat (2500) @(posedge pclk);
		rd(rxgc_pkg::RXGC_OFS_LIVE, 32'h3, "live settled");
		mrt_count <= sqt;
		sq_tgt <= 4'ha;
		repeat (4500) @(posedge pclk);
		rd(rxgc_pkg::RXGC_OFS_LIVE, 32'h3, "live stopped");
		setup(8'h03, 8'h00);
		mrt_count <= 8'h00;
		sq6_tgt <= 4'h5;
		pulse_tx();
		wait_live(5);
		repeat (4500) @(posedge pclk);
		rd(rxgc_pkg::RXGC_OFS_LIVE, 32'h5, "live ratio6");
		mrt_count <= sqt;
		apb(1'b1, rxgc_pkg::RXGC_OFS_CMD, 32'h1);
		wait_live(0);
		close_out();
	end
endmodule
`default_nettype wire
